// [ssm_consts.svh]
// constants for the socket status management interrupt block
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// register indexes on the index port
`define SSM_IDX_STATUS    8'h04
`define SSM_IDX_CONFIG    8'h05

// reset values
`define SSM_CFG_RESET     8'h00
`define SSM_FLAG_RESET    4'h0
`define SSM_LVL_RESET     5'h1F
`define SSM_RDATA_RESET   8'h00
`define SSM_FLAG_PAD      4'h0
`define SSM_IRQ_RESET     16'h0000
`define SSM_SMI_RESET     1'h0
`define SSM_INTX_IDLE     1'h1

// flag and enable bit positions, shared by both registers
`define SSM_BIT_STSCHG    0
`define SSM_BIT_BATWARN   1
`define SSM_BIT_READY     2
`define SSM_BIT_CDET      3
`define SSM_EN_MSB        3
`define SSM_ROUTE_LSB     4
`define SSM_ROUTE_MSB     7
// position of the SMI line in the decoded route vector
`define SSM_SMI_POS       16

// pin positions inside the packed pin group
`define SSM_PIN_STS       4
`define SSM_PIN_BAT       3
`define SSM_PIN_RDY       2
`define SSM_PIN_CD1       1
`define SSM_PIN_CD2       0

// routing codes
`define SSM_ROUTE_OFF     4'h0
`define SSM_ROUTE_IRQ1    4'h1
`define SSM_ROUTE_SMI     4'h2
`define SSM_ROUTE_IRQ6    4'h6
`define SSM_ROUTE_IRQ8    4'h8
`define SSM_ROUTE_IRQ13   4'hD

// settling count before pin edges are believed after reset
`define SSM_PRIME_DONE    2'h3
`define SSM_PRIME_STEP    2'h1
`define SSM_PRIME_RESET   2'h0

`endif

// [ssm_pkg.sv]
// types for the socket status management interrupt block
`default_nettype none
package ssm_pkg;

   // interrupt signalling scheme chosen by the system
   typedef enum logic [1:0] {
      SSM_MODE_SERIAL,
      SSM_MODE_SERBUS,
      SSM_MODE_PCI
   } ssm_mode_t;

   // card status pins of one socket, raw levels
   typedef struct packed {
      logic status_change_pin;
      logic battery_warning_pin;
      logic card_ready_pin;
      logic card_detect_pin_one;
      logic card_detect_pin_two;
   } ssm_pins_t;

endpackage : ssm_pkg
`default_nettype wire

// [ssm_irq.sv]
// per-socket card status change flags and management interrupt routing
//
// Function
// - Status-change enable and its flag raise a management interrupt.
// - Battery-warning enable and its flag raise one, memory mode only.
// - Ready enable and the ready-change flag raise one, memory mode only.
// - Card-detect enable and the card-detect change flag raise one.
// - In serial modes the route field picks IRQn and zero turns it off.
// - Codes 1, 2, 6, 8 and 13 work only in serialized bus mode, 2 is SMI.
// - PCI signalling ignores the route: socket A on INTA#, B on INTB#.
// - With the ring output reroute on, socket B INTB# traffic goes to INTA#.
// - Config clears on reset but survives a segment reset with wake armed.
// - Each socket owns a configuration register of enables and route.
// - Status flag sets on a fall in memory mode, any edge in I/O mode.
// - Card-detect flag sets when either detect pin moves; a read clears.
`include "ssm_consts.svh"
`default_nettype none
module ssm_irq #(
   parameter int unsigned SYNC_STAGES = 3
) (
   input  wire  logic                        SYS_CLK_IN,
   input  wire  logic                        RESET_N_IN,
   input  wire  ssm_pkg::ssm_pins_t [1:0]    SOCKET_PINS_IN,
   input  wire  logic [1:0]                  CARD_IS_IO_IN,
   input  wire  logic [1:0]                  CARD_IRQ_IN,
   input  wire  ssm_pkg::ssm_mode_t          INT_MODE_IN,
   input  wire  logic                        RING_OUTPUT_REROUTE_IN,
   input  wire  logic                        WAKE_ENABLE_IN,
   input  wire  logic                        SEG_RESET_IN,
   input  wire  logic                        REG_SOCKET_IN,
   input  wire  logic [7:0]                  REG_INDEX_IN,
   input  wire  logic                        REG_WR_IN,
   input  wire  logic                        REG_RD_IN,
   input  wire  logic [7:0]                  REG_WDATA_IN,
   output var   logic [7:0]                  REG_RDATA_OUT,
   output var   logic [15:0]                 LEGACY_IRQ_OUT,
   output var   logic                        SMI_OUT,
   output var   logic                        INTA_N_OUT,
   output var   logic                        INTB_N_OUT
);

   localparam int unsigned NPINS = 5;

   // per-socket results collected for the shared output stage
   logic [1:0]        mgmt_req;
   logic [1:0][15:0]  irq_vec;
   logic [1:0]        smi_vec;
   logic [1:0][3:0]   flags_rd;
   logic [1:0][7:0]   cfg_rd;

   // routing decode: serial modes only, reserved codes act as off outside the serialized bus mode
   function automatic logic [16:0] route_decode(
      input logic [3:0]         code,
      input ssm_pkg::ssm_mode_t mode,
      input logic               req
   );
      logic [16:0] res;
      logic        restricted;
      res        = 17'h00000;
      restricted = (code == `SSM_ROUTE_IRQ1) || (code == `SSM_ROUTE_SMI) ||
                   (code == `SSM_ROUTE_IRQ6) || (code == `SSM_ROUTE_IRQ8) ||
                   (code == `SSM_ROUTE_IRQ13);
      if (req && mode != ssm_pkg::SSM_MODE_PCI &&
          code != `SSM_ROUTE_OFF &&
          (!restricted || mode == ssm_pkg::SSM_MODE_SERBUS)) begin
         if (code == `SSM_ROUTE_SMI) begin
            res[`SSM_SMI_POS] = 1'h1;
         end else begin
            res[code] = 1'h1;
         end
      end
      return res;
   endfunction : route_decode

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sock
         logic [NPINS-1:0] sync_q [SYNC_STAGES];
         logic [NPINS-1:0] lvl_q;
         logic [NPINS-1:0] lvl_d;
         logic [NPINS-1:0] agree;
         logic [NPINS-1:0] fall;
         logic [NPINS-1:0] chg;
         logic [1:0]       prime_q;
         logic             primed;
         logic [3:0]       ev;
         logic [3:0]       flags_q;
         logic [7:0]       cfg_q;
         logic             sel;
         logic             clr_rd;
         logic             cfg_wr;
         logic             ctx_clear;
         logic [16:0]      routed;

         // three-stage pin synchroniser; stage 0 feeds only stage 1
         always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               for (int i = 0; i < SYNC_STAGES; i++) begin
                  sync_q[i] <= `SSM_LVL_RESET;
               end
            end else begin
               sync_q[0] <= SOCKET_PINS_IN[g];
               for (int i = 1; i < SYNC_STAGES; i++) begin
                  sync_q[i] <= sync_q[i-1];
               end
            end
         end

         // a level counts only when the last two stages agree
         assign agree = ~(sync_q[SYNC_STAGES-2] ^ sync_q[SYNC_STAGES-1]);
         assign lvl_d = (agree & sync_q[SYNC_STAGES-1]) | (~agree & lvl_q);
         assign fall  = lvl_q & ~lvl_d;
         assign chg   = lvl_q ^ lvl_d;
         assign primed = (prime_q == `SSM_PRIME_DONE);

         // settle three cycles; a pin not at the reset value still makes one event on the cycle after they end
         always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               prime_q <= `SSM_PRIME_RESET;
               lvl_q   <= `SSM_LVL_RESET;
            end else begin
               lvl_q <= lvl_d;
               if (!primed) begin
                  prime_q <= prime_q + `SSM_PRIME_STEP;
               end
            end
         end

         // edge selection per flag, depending on card interface mode
         always_comb begin
            ev = 4'h0;
            if (primed) begin
               ev[`SSM_BIT_STSCHG] = CARD_IS_IO_IN[g] ? chg[`SSM_PIN_STS]
                                                      : fall[`SSM_PIN_STS];
               ev[`SSM_BIT_BATWARN] = !CARD_IS_IO_IN[g] && fall[`SSM_PIN_BAT];
               ev[`SSM_BIT_READY] = !CARD_IS_IO_IN[g] && chg[`SSM_PIN_RDY];
               ev[`SSM_BIT_CDET] = chg[`SSM_PIN_CD1] | chg[`SSM_PIN_CD2];
            end
         end

         assign sel       = (REG_SOCKET_IN == 1'(g));
         assign clr_rd    = sel && REG_RD_IN &&
                            (REG_INDEX_IN == `SSM_IDX_STATUS);
         assign cfg_wr    = sel && REG_WR_IN &&
                            (REG_INDEX_IN == `SSM_IDX_CONFIG);
         // context kept while wake is armed
         assign ctx_clear = SEG_RESET_IN && !WAKE_ENABLE_IN;

         // sticky flags; a new event beats the read that clears
         always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               flags_q <= `SSM_FLAG_RESET;
            end else if (ctx_clear) begin
               flags_q <= `SSM_FLAG_RESET;
            end else begin
               flags_q <= (flags_q & ~{4{clr_rd}}) | ev;
            end
         end

         always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               cfg_q <= `SSM_CFG_RESET;
            end else if (ctx_clear) begin
               cfg_q <= `SSM_CFG_RESET;
            end else if (cfg_wr) begin
               cfg_q <= REG_WDATA_IN;
            end
         end

         assign mgmt_req[g] = |(flags_q & cfg_q[`SSM_EN_MSB:0]);

         assign routed = route_decode(cfg_q[`SSM_ROUTE_MSB:`SSM_ROUTE_LSB],
                                      INT_MODE_IN, mgmt_req[g]);
         assign irq_vec[g]  = routed[`SSM_SMI_POS-1:0];
         assign smi_vec[g]  = routed[`SSM_SMI_POS];
         assign flags_rd[g] = flags_q;
         assign cfg_rd[g]   = cfg_q;
      end
   endgenerate

   logic pci_mode;
   logic sock_a_req;
   logic sock_b_req;

   assign pci_mode   = (INT_MODE_IN == ssm_pkg::SSM_MODE_PCI);
   assign sock_a_req = mgmt_req[0] | CARD_IRQ_IN[0];
   assign sock_b_req = mgmt_req[1] | CARD_IRQ_IN[1];

   // output lines from flops so the pins never glitch
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         LEGACY_IRQ_OUT <= `SSM_IRQ_RESET;
         SMI_OUT        <= `SSM_SMI_RESET;
      end else begin
         LEGACY_IRQ_OUT <= irq_vec[0] | irq_vec[1];
         SMI_OUT        <= smi_vec[0] | smi_vec[1];
      end
   end

   // PCI lines are active low and idle high outside PCI signalling
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         INTA_N_OUT <= `SSM_INTX_IDLE;
         INTB_N_OUT <= `SSM_INTX_IDLE;
      end else begin
         INTA_N_OUT <= !(pci_mode && (sock_a_req ||
                         (RING_OUTPUT_REROUTE_IN && sock_b_req)));
         INTB_N_OUT <= !(pci_mode && !RING_OUTPUT_REROUTE_IN && sock_b_req);
      end
   end

   // read data one cycle after the strobe; unmapped indexes read zero
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         REG_RDATA_OUT <= `SSM_RDATA_RESET;
      end else if (REG_RD_IN) begin
         if (REG_INDEX_IN == `SSM_IDX_STATUS) begin
            REG_RDATA_OUT <= {`SSM_FLAG_PAD, flags_rd[REG_SOCKET_IN]};
         end else if (REG_INDEX_IN == `SSM_IDX_CONFIG) begin
            REG_RDATA_OUT <= cfg_rd[REG_SOCKET_IN];
         end else begin
            REG_RDATA_OUT <= `SSM_RDATA_RESET;
         end
      end
   end

endmodule : ssm_irq
`default_nettype wire

// [ssm_irq_chk.sv]
// port checks for the management interrupt block
`default_nettype none
module ssm_irq_chk (
   input wire logic               SYS_CLK_IN,
   input wire logic               RESET_N_IN,
   input wire logic [1:0]         CARD_IRQ_IN,
   input wire ssm_pkg::ssm_mode_t INT_MODE_IN,
   input wire logic               RING_OUTPUT_REROUTE_IN,
   input wire logic [7:0]         REG_INDEX_IN,
   input wire logic               REG_RD_IN,
   input wire logic [7:0]         REG_RDATA_OUT,
   input wire logic [15:0]        LEGACY_IRQ_OUT,
   input wire logic               SMI_OUT,
   input wire logic               INTA_N_OUT,
   input wire logic               INTB_N_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);
   // decoded mode and status read, shared by several checks
   wire logic pci = INT_MODE_IN == ssm_pkg::SSM_MODE_PCI;
   wire logic ser = INT_MODE_IN == ssm_pkg::SSM_MODE_SERIAL;
   wire logic sts = REG_RD_IN && REG_INDEX_IN == 8'h04;
   a_rdata_hold: assert property (
      !REG_RD_IN |=> $stable(REG_RDATA_OUT)) else $error("rdata moved");
   a_unmap_zero: assert property (
      REG_RD_IN && REG_INDEX_IN[7:1] != 7'h02 |=> REG_RDATA_OUT == 8'h00)
      else $error("unmapped read not zero");
   a_status_pad: assert property (
      sts |=> REG_RDATA_OUT[7:4] == 4'h0) else $error("status pad set");
   a_pci_quiet: assert property (
      pci |=> LEGACY_IRQ_OUT == 16'h0000 && !SMI_OUT)
      else $error("legacy line in pci mode");
   a_legacy_intx: assert property (
      !pci |=> INTA_N_OUT && INTB_N_OUT) else $error("intx outside pci");
   // reserved codes drive nothing outside the serialized bus mode
   a_serial_resv: assert property (
      ser |=> (LEGACY_IRQ_OUT & 16'h2142) == 16'h0000 && !SMI_OUT)
      else $error("reserved code routed");
   a_card_inta: assert property (
      pci && CARD_IRQ_IN[0] |=> !INTA_N_OUT) else $error("card a lost");
   a_reroute_b: assert property (
      pci && RING_OUTPUT_REROUTE_IN |=> INTB_N_OUT)
      else $error("intb used while rerouted");
   c_status_read: cover property (sts);
   c_smi_seen: cover property (SMI_OUT);
   c_rerouted: cover property (pci && RING_OUTPUT_REROUTE_IN && !INTA_N_OUT);
endmodule : ssm_irq_chk
bind ssm_irq ssm_irq_chk ssm_irq_chk_i (.SYS_CLK_IN, .RESET_N_IN,
   .CARD_IRQ_IN, .INT_MODE_IN, .RING_OUTPUT_REROUTE_IN, .REG_INDEX_IN,
   .REG_RD_IN, .REG_RDATA_OUT, .LEGACY_IRQ_OUT, .SMI_OUT, .INTA_N_OUT,
   .INTB_N_OUT);
`default_nettype wire

// [ssm_card_model.sv]
// card side model: status pins of two sockets
`default_nettype none
module ssm_card_model (
   input  wire logic                     clk_in,
   output var  ssm_pkg::ssm_pins_t [1:0] pins_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins rest high, as the socket pull-ups leave them
   initial pins_out = '1;
   // one level change, launched away from the sampling edge
   task automatic flip(input int s, input int b);
      @(negedge clk_in);
      pins_out[s][b] = !pins_out[s][b];
   endtask : flip
endmodule : ssm_card_model
`default_nettype wire

// [ssm_irq_tb.sv]
// self-checking bench for the management interrupt block
`default_nettype none
module ssm_irq_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     clk, rst_n, ring, wake, seg, sock, wr, rd;
   logic                     smi, inta_n, intb_n;
   logic [1:0]               io, cirq;
   logic [7:0]               idx, wd, rdata;
   logic [15:0]              irq;
   ssm_pkg::ssm_mode_t       mode;
   ssm_pkg::ssm_pins_t [1:0] pins;
   int                       err_total, checks_done;
   ssm_irq ssm_irq_i (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
      .SOCKET_PINS_IN(pins), .CARD_IS_IO_IN(io), .CARD_IRQ_IN(cirq),
      .INT_MODE_IN(mode), .RING_OUTPUT_REROUTE_IN(ring),
      .WAKE_ENABLE_IN(wake), .SEG_RESET_IN(seg), .REG_SOCKET_IN(sock),
      .REG_INDEX_IN(idx), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdata), .LEGACY_IRQ_OUT(irq),
      .SMI_OUT(smi), .INTA_N_OUT(inta_n), .INTB_N_OUT(intb_n));
   ssm_card_model ssm_card_model_i (.clk_in(clk), .pins_out(pins));
   // free-running system clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(logic [18:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   // strobes move on falling edges, away from sampling
   task automatic wreg(logic s, logic [7:0] i, d);
      @(negedge clk);
      {sock, idx, wd, wr} = {s, i, d, 1'b1};
      @(negedge clk);
      wr = 1'b0;
   endtask : wreg
   task automatic rchk(logic s, logic [7:0] i, e);
      @(negedge clk);
      {sock, idx, rd} = {s, i, 1'b1};
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      check(rdata, e);
   endtask : rchk
   // pin change, lines while held, status read, then lines idle again
   task automatic ev(int s, b, logic [16:0] ln, logic [1:0] ab,
                     logic [7:0] st);
      ssm_card_model_i.flip(s, b);
      repeat (8) @(negedge clk);
      check({smi, irq, inta_n, intb_n}, {ln, ab});
      rchk(s[0], 8'h04, st);
      check({smi, irq, inta_n, intb_n}, {17'h0, 2'b11});
   endtask : ev
   task automatic t_regs;
      rchk(1'b0, 8'h05, 8'h00);
      wreg(1'b0, 8'h05, 8'h5F);
      wreg(1'b1, 8'h05, 8'hF9);
      wreg(1'b0, 8'h04, 8'hFF);
      rchk(1'b0, 8'h05, 8'h5F);
      rchk(1'b1, 8'h05, 8'hF9);
      rchk(1'b0, 8'h04, 8'h00);
      rchk(1'b0, 8'h06, 8'h00);
      $display("register test done");
   endtask : t_regs
   task automatic t_serial;
      ev(0, 3, 17'h20, 2'b11, 8'h02);
      ev(0, 2, 17'h20, 2'b11, 8'h04);
      ev(0, 4, 17'h20, 2'b11, 8'h01);
      ev(0, 4, 17'h00, 2'b11, 8'h00);
      ev(0, 0, 17'h20, 2'b11, 8'h08);
      ev(1, 1, 17'h8000, 2'b11, 8'h08);
      wreg(1'b0, 8'h05, 8'h57);
      ev(0, 0, 17'h00, 2'b11, 8'h08);
      io = 2'b01;
      ev(0, 4, 17'h20, 2'b11, 8'h01);
      ev(0, 4, 17'h20, 2'b11, 8'h01);
      ev(0, 2, 17'h00, 2'b11, 8'h00);
      io = 2'b00;
      $display("serial routing test done");
   endtask : t_serial
   task automatic t_codes;
      logic [3:0]  c [5] = '{4'h1, 4'h2, 4'h6, 4'h8, 4'hD};
      logic [16:0] ln;
      foreach (c[k]) begin
         mode = ssm_pkg::SSM_MODE_SERBUS;
         wreg(1'b0, 8'h05, {c[k], 4'h8});
         // code 2 lands on the SMI line, the others on their own IRQ
         ln = (c[k] == 4'h2) ? 17'h10000 : 17'h1 << c[k];
         ev(0, 0, ln, 2'b11, 8'h08);
         mode = ssm_pkg::SSM_MODE_SERIAL;
         ev(0, 0, 17'h0, 2'b11, 8'h08);
      end
      $display("bus code test done");
   endtask : t_codes
   task automatic t_pci;
      mode = ssm_pkg::SSM_MODE_PCI;
      ev(0, 0, 17'h0, 2'b01, 8'h08);
      ev(1, 0, 17'h0, 2'b10, 8'h08);
      ring = 1'b1;
      ev(1, 0, 17'h0, 2'b01, 8'h08);
      cirq = 2'b11;
      repeat (2) @(negedge clk);
      check({smi, irq, inta_n, intb_n}, {17'h0, 2'b01});
      {cirq, ring} = 3'h0;
      mode = ssm_pkg::SSM_MODE_SERIAL;
      $display("pci signalling test done");
   endtask : t_pci
   // segment reset keeps context only while wake is armed
   task automatic t_seg;
      for (int w = 1; w >= 0; w--) begin
         wake = w[0];
         @(negedge clk) seg = 1'b1;
         @(negedge clk) seg = 1'b0;
         rchk(1'b1, 8'h05, w ? 8'hF9 : 8'h00);
      end
      $display("segment reset test done");
   endtask : t_seg
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run
   // reset for three cycles, then let the pin pipe settle
   initial begin
      {rst_n, ring, wake, seg, sock, wr, rd, io, cirq, idx, wd} = '0;
      mode = ssm_pkg::SSM_MODE_SERIAL;
      err_total = 0;
      checks_done = 0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_regs;
      t_serial;
      t_codes;
      t_pci;
      t_seg;
      complete_run;
   end
   // a hang counts as a mismatch rather than a silent stall
   initial begin
      repeat (4000) @(posedge clk);
      err_total++;
      complete_run;
   end
endmodule : ssm_irq_tb
`default_nettype wire
